/* File: rtl/accdp_pkg.sv */
package accdp_pkg;
  localparam int ACC_W = 32;
  localparam int WORD_W = 16;
  localparam int DADDR_W = 8;
  localparam int AR_W = 16;
  localparam int NUM_AR = 2;
  localparam int STACK_DEPTH = 4;
  localparam logic [31:0] ACC_MAX_POS = 32'h7fffffff;
  localparam logic [31:0] ACC_MAX_NEG = 32'h80000000;
  localparam logic [31:0] ACC_RESET = 32'h00000000;
  localparam logic [15:0] AR_RESET = 16'h0000;
  localparam int STATUS_W = 16;
  localparam int ST_SAT_POS = 10;
  localparam int ST_OVF_POS = 15;
  localparam int ST_ARP_POS = 8;
  localparam int PROG_COPY_CYCLES = 3;
  localparam logic [1:0] PROG_COPY_LAST = 2'(PROG_COPY_CYCLES - 1);
  typedef enum logic [4:0] {
    ACCDP_NOP, ACCDP_ADD, ACCDP_SUB, ACCDP_LOAD_SHIFTED, ACCDP_ZERO_LOAD_HIGH,
    ACCDP_ZERO_LOAD_LOW, ACCDP_CLEAR_ACC, ACCDP_MAGNITUDE, ACCDP_AND, ACCDP_OR,
    ACCDP_XOR, ACCDP_STORE_HIGH, ACCDP_STORE_LOW, ACCDP_PUSH, ACCDP_POP,
    ACCDP_SAT_ON, ACCDP_SAT_OFF, ACCDP_STATUS_RELOAD, ACCDP_BR_RANGE,
    ACCDP_BR_ZERO, ACCDP_LOOP_BR, ACCDP_P2D_COPY, ACCDP_D2P_COPY,
    ACCDP_PORT_IN, ACCDP_PORT_OUT, ACCDP_AUX_LOAD_IMM, ACCDP_AUX_PTR_SEL
  } accdp_op_t;
  typedef enum logic [1:0] {ACCDP_IDLE, ACCDP_COPY} accdp_state_t;
endpackage : accdp_pkg

/* File: rtl/accdp_core.sv */
// Behaviour
// - saturation on: overflow replaces accumulator with largest positive or negative
// - saturate enable set by saturate_on, cleared by saturate_off, written by reload
// - range flag is not carry, sets on overflow, stays until cleared
// - branch testing range flag clears it, taken or not
// - branch_on_range_exceed jumps to target when range flag set
// - saturation covers every arithmetic ALU operation on the accumulator
// - zero-load high, zero-load low and shifted load clear accumulator first
// - clear_accumulator sets every accumulator bit to zero
// - magnitude_op replaces accumulator with its absolute value
// - store high and store low write accumulator halves to data memory
// - push saves accumulator onto hardware stack
// - pop restores accumulator from top of hardware stack
// - program-to-data copy reads program word at accumulator into data memory
// - data-to-program copy writes data word to program memory at accumulator
// - port in/out moves one word between data memory and selected port
// - loop branch jumps while current aux nonzero, decrements it, N+1 passes
// - post-increment uses current aux as address, increments, may switch pointer
// - and/or/xor combine with data word; shifted load shifts left by count
// - branch_if_zero jumps when accumulator equals zero
// - program-to-data copy takes three instruction cycles
`timescale 1ns/100ps
`default_nettype none
module accdp_core
  import accdp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic op_valid_i,
  input wire accdp_op_t op_i,
  input wire logic [WORD_W-1:0] dmem_rdata_i,
  input wire logic [3:0] shift_i,
  input wire logic [DADDR_W-1:0] direct_addr_i,
  input wire logic indirect_i,
  input wire logic post_inc_i,
  input wire logic new_ptr_valid_i,
  input wire logic new_ptr_i,
  input wire logic [AR_W-1:0] imm_i,
  input wire logic [STATUS_W-1:0] status_wdata_i,
  input wire logic [2:0] port_sel_i,
  input wire logic [WORD_W-1:0] port_rdata_i,
  input wire logic [WORD_W-1:0] pmem_rdata_i,
  output logic busy_o,
  output logic [DADDR_W-1:0] dmem_addr_o,
  output logic dmem_we_o,
  output logic [WORD_W-1:0] dmem_wdata_o,
  output logic [WORD_W-1:0] pmem_addr_o,
  output logic pmem_re_o,
  output logic pmem_we_o,
  output logic [WORD_W-1:0] pmem_wdata_o,
  output logic [2:0] port_addr_o,
  output logic port_re_o,
  output logic port_we_o,
  output logic [WORD_W-1:0] port_wdata_o,
  output logic branch_taken_o,
  output logic [ACC_W-1:0] acc_o,
  output logic saturate_enable_bit_o,
  output logic range_exceed_flag_o,
  output logic aux_ptr_o
);
  logic [ACC_W-1:0] acc_q, acc_d;
  logic sat_q, sat_d, ovf_q, ovf_d, arp_q, arp_d;
  logic [AR_W-1:0] ar_q [NUM_AR];
  logic [ACC_W-1:0] stk_q [STACK_DEPTH];
  accdp_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic [DADDR_W-1:0] cp_addr_q;
  logic [WORD_W-1:0] cp_data_q;
  logic [WORD_W-1:0] dwr_q, pwd_q, powd_q;
  logic [DADDR_W-1:0] da_q;
  logic dwe_q, pre_q, pwe_q, pre2_q, pwe2_q, br_q;
  logic [WORD_W-1:0] pa_q;
  logic [2:0] pta_q;

  wire go = op_valid_i && state_q == ACCDP_IDLE;
  wire [AR_W-1:0] cur_ar = ar_q[arp_q];
  wire [DADDR_W-1:0] eff_addr = indirect_i ? cur_ar[DADDR_W-1:0] : direct_addr_i;
  wire [ACC_W-1:0] sdat = ACC_W'({{16{dmem_rdata_i[15]}}, dmem_rdata_i}) << shift_i;
  wire is_sub = op_i == ACCDP_SUB;
  wire [ACC_W-1:0] addend = is_sub ? ~sdat : sdat;
  wire [ACC_W-1:0] sum = acc_q + addend + {31'h0, is_sub};
  wire arith_ovf = (acc_q[31] == addend[31]) && (sum[31] != acc_q[31]);
  wire [ACC_W-1:0] neg = ACC_W'(0) - acc_q;
  wire abs_ovf = acc_q == ACC_MAX_NEG;
  wire is_arith = op_i == ACCDP_ADD || is_sub;
  wire ovf_evt = go && ((is_arith && arith_ovf) || (op_i == ACCDP_MAGNITUDE && abs_ovf));
  wire [ACC_W-1:0] sat_val = acc_q[31] ? ACC_MAX_NEG : ACC_MAX_POS;
  wire [ACC_W-1:0] sum_sat = (sat_q && arith_ovf) ? sat_val : sum;
  wire [ACC_W-1:0] abs_val = acc_q[31] ? ((sat_q && abs_ovf) ? ACC_MAX_POS : neg) : acc_q;
  wire ar_nz = cur_ar != AR_RESET;

  always_comb begin
    acc_d = acc_q;
    if (go) begin
      case (op_i)
        ACCDP_ADD, ACCDP_SUB: acc_d = sum_sat;
        ACCDP_LOAD_SHIFTED: acc_d = sdat;
        ACCDP_ZERO_LOAD_HIGH: acc_d = {dmem_rdata_i, 16'h0000};
        ACCDP_ZERO_LOAD_LOW: acc_d = {16'h0000, dmem_rdata_i};
        ACCDP_CLEAR_ACC: acc_d = ACC_RESET;
        ACCDP_MAGNITUDE: acc_d = abs_val;
        ACCDP_AND: acc_d = {16'h0000, acc_q[15:0] & dmem_rdata_i};
        ACCDP_OR: acc_d = {acc_q[31:16], acc_q[15:0] | dmem_rdata_i};
        ACCDP_XOR: acc_d = {acc_q[31:16], acc_q[15:0] ^ dmem_rdata_i};
        ACCDP_POP: acc_d = stk_q[0];
        default: acc_d = acc_q;
      endcase
    end
  end

  always_comb begin
    sat_d = sat_q;
    ovf_d = ovf_q;
    arp_d = arp_q;
    if (go) begin
      case (op_i)
        ACCDP_SAT_ON: sat_d = 1'b1;
        ACCDP_SAT_OFF: sat_d = 1'b0;
        ACCDP_STATUS_RELOAD: begin
          sat_d = status_wdata_i[ST_SAT_POS];
          ovf_d = status_wdata_i[ST_OVF_POS];
          arp_d = status_wdata_i[ST_ARP_POS];
        end
        ACCDP_BR_RANGE: ovf_d = 1'b0;
        ACCDP_AUX_PTR_SEL: arp_d = imm_i[0];
        default: ;
      endcase
      if (indirect_i && new_ptr_valid_i) begin
        arp_d = new_ptr_i;
      end
    end
    if (ovf_evt) begin
      ovf_d = 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ACCDP_IDLE: begin
        if (go && op_i == ACCDP_P2D_COPY) begin
          state_d = ACCDP_COPY;
          cnt_d = 2'd1;
        end
      end
      ACCDP_COPY: begin
        cnt_d = cnt_q + 2'd1;
        if (cnt_q == PROG_COPY_LAST) begin
          state_d = ACCDP_IDLE;
          cnt_d = 2'd0;
        end
      end
      default: state_d = ACCDP_IDLE;
    endcase
  end

  assign busy_o = state_q != ACCDP_IDLE;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_q <= ACC_RESET;
      sat_q <= 1'b0;
      ovf_q <= 1'b0;
      arp_q <= 1'b0;
      state_q <= ACCDP_IDLE;
      cnt_q <= 2'd0;
    end else begin
      acc_q <= acc_d;
      sat_q <= sat_d;
      ovf_q <= ovf_d;
      arp_q <= arp_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_AR; g++) begin : gen_ar
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          ar_q[g] <= AR_RESET;
        end else if (go && op_i == ACCDP_AUX_LOAD_IMM && arp_q == 1'(g)) begin
          ar_q[g] <= imm_i;
        end else if (go && op_i == ACCDP_LOOP_BR && arp_q == 1'(g) && ar_nz) begin
          ar_q[g] <= cur_ar - 16'h0001;
        end else if (go && indirect_i && post_inc_i && arp_q == 1'(g)) begin
          ar_q[g] <= cur_ar + 16'h0001;
        end
      end
    end
    for (g = 0; g < STACK_DEPTH; g++) begin : gen_stk
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          stk_q[g] <= ACC_RESET;
        end else if (go && op_i == ACCDP_PUSH) begin
          stk_q[g] <= (g == 0) ? acc_q : stk_q[(g == 0) ? 0 : g-1];
        end else if (go && op_i == ACCDP_POP) begin
          stk_q[g] <= (g == STACK_DEPTH-1) ? stk_q[g] : stk_q[(g == STACK_DEPTH-1) ? g : g+1];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cp_addr_q <= '0;
      cp_data_q <= '0;
    end else if (go && op_i == ACCDP_P2D_COPY) begin
      cp_addr_q <= eff_addr;
    end else if (state_q == ACCDP_COPY && cnt_q == 2'd1) begin
      cp_data_q <= pmem_rdata_i;
    end
  end

  wire st_hi = go && op_i == ACCDP_STORE_HIGH;
  wire st_lo = go && op_i == ACCDP_STORE_LOW;
  wire p_in = go && op_i == ACCDP_PORT_IN;
  wire cp_wr = state_q == ACCDP_COPY && cnt_q == PROG_COPY_LAST;
  wire [WORD_W-1:0] dwr_d = st_hi ? acc_q[31:16] : st_lo ? acc_q[15:0] :
                            p_in ? port_rdata_i : cp_data_q;
  wire br_d = go && ((op_i == ACCDP_BR_RANGE && ovf_q) ||
                     (op_i == ACCDP_BR_ZERO && acc_q == ACC_RESET) ||
                     (op_i == ACCDP_LOOP_BR && ar_nz));

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dwe_q <= 1'b0;
      da_q <= '0;
      dwr_q <= '0;
      br_q <= 1'b0;
    end else begin
      dwe_q <= st_hi || st_lo || p_in || cp_wr;
      da_q <= cp_wr ? cp_addr_q : eff_addr;
      dwr_q <= dwr_d;
      br_q <= br_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pa_q <= '0;
      pre_q <= 1'b0;
      pwe_q <= 1'b0;
      pwd_q <= '0;
      pta_q <= '0;
      pre2_q <= 1'b0;
      pwe2_q <= 1'b0;
      powd_q <= '0;
    end else begin
      pa_q <= acc_q[15:0];
      pre_q <= go && op_i == ACCDP_P2D_COPY;
      pwe_q <= go && op_i == ACCDP_D2P_COPY;
      pwd_q <= dmem_rdata_i;
      pta_q <= port_sel_i;
      pre2_q <= p_in;
      pwe2_q <= go && op_i == ACCDP_PORT_OUT;
      powd_q <= dmem_rdata_i;
    end
  end

  assign dmem_addr_o = busy_o ? cp_addr_q : eff_addr;
  assign dmem_we_o = dwe_q;
  assign dmem_wdata_o = dwr_q;
  assign pmem_addr_o = pa_q;
  assign pmem_re_o = pre_q;
  assign pmem_we_o = pwe_q;
  assign pmem_wdata_o = pwd_q;
  assign port_addr_o = pta_q;
  assign port_re_o = pre2_q;
  assign port_we_o = pwe2_q;
  assign port_wdata_o = powd_q;
  assign branch_taken_o = br_q;
  assign acc_o = acc_q;
  assign saturate_enable_bit_o = sat_q;
  assign range_exceed_flag_o = ovf_q;
  assign aux_ptr_o = arp_q;
endmodule : accdp_core
`default_nettype wire

/* File: tb/accdp_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module accdp_asserts
  import accdp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic op_valid_i,
  input wire accdp_op_t op_i,
  input wire logic [WORD_W-1:0] dmem_rdata_i,
  input wire logic busy_o,
  input wire logic dmem_we_o,
  input wire logic branch_taken_o,
  input wire logic [ACC_W-1:0] acc_o,
  input wire logic saturate_enable_bit_o,
  input wire logic range_exceed_flag_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic tk = op_valid_i && !busy_o;
  property p_clr; tk && op_i == ACCDP_CLEAR_ACC |=> acc_o == ACC_RESET; endproperty
  a_clr: assert property (p_clr) else $error("clear failed");
  property p_zlh; tk && op_i == ACCDP_ZERO_LOAD_HIGH |=> acc_o == {$past(dmem_rdata_i), 16'h0000};
  endproperty
  a_zlh: assert property (p_zlh) else $error("zero load high");
  property p_sat; tk && saturate_enable_bit_o && op_i inside {ACCDP_ADD, ACCDP_SUB} ##1
    $rose(range_exceed_flag_o) |-> acc_o == ACC_MAX_POS || acc_o == ACC_MAX_NEG; endproperty
  a_sat: assert property (p_sat) else $error("no saturation");
  property p_brc; tk && op_i == ACCDP_BR_RANGE |=> !range_exceed_flag_o; endproperty
  a_brc: assert property (p_brc) else $error("flag kept");
  property p_br; tk && op_i == ACCDP_BR_RANGE && range_exceed_flag_o |=> branch_taken_o; endproperty
  a_br: assert property (p_br) else $error("range branch");
  property p_bz; tk && op_i == ACCDP_BR_ZERO |=> branch_taken_o == ($past(acc_o) == 0); endproperty
  a_bz: assert property (p_bz) else $error("zero branch");
  property p_stk; range_exceed_flag_o && !(tk && op_i inside {ACCDP_BR_RANGE,
    ACCDP_STATUS_RELOAD}) |=> range_exceed_flag_o; endproperty
  a_stk: assert property (p_stk) else $error("flag lost");
  property p_cpy; tk && op_i == ACCDP_P2D_COPY |=> busy_o [*2] ##1 (!busy_o && dmem_we_o);
  endproperty
  a_cpy: assert property (p_cpy) else $error("copy timing");
endmodule : accdp_asserts
bind accdp_core accdp_asserts accdp_asserts_inst (.ref_clk_i, .reset_n_i, .op_valid_i, .op_i,
  .dmem_rdata_i, .busy_o, .dmem_we_o, .branch_taken_o, .acc_o, .saturate_enable_bit_o,
  .range_exceed_flag_o);
`default_nettype wire

/* File: tb/accdp_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module accdp_far_model (
  input wire logic clk_i,
  input wire logic [15:0] pm_addr_i,
  input wire logic pm_re_i,
  input wire logic pm_we_i,
  input wire logic [15:0] pm_wdata_i,
  input wire logic [2:0] pt_sel_i,
  input wire logic [2:0] pt_addr_i,
  input wire logic pt_we_i,
  input wire logic [15:0] pt_wdata_i,
  output logic [15:0] pm_rdata_o,
  output logic [15:0] pt_rdata_o
);
  logic [15:0] pm [256];
  logic [15:0] pt [8];
  logic [15:0] last_q = 16'h0000;
  // idle bus shows inverse of last word
  assign pm_rdata_o = pm_re_i ? pm[pm_addr_i[7:0]] : ~last_q;
  assign pt_rdata_o = pt[pt_sel_i];
  initial for (int i = 0; i < 256; i++) pm[i] = 16'(i);
  initial for (int i = 0; i < 8; i++) pt[i] = 16'hffff;
  always @(posedge clk_i) begin
    last_q <= pm_rdata_o;
    if (pm_we_i) pm[pm_addr_i[7:0]] <= pm_wdata_i;
    if (pt_we_i) pt[pt_addr_i] <= pt_wdata_i;
  end
endmodule : accdp_far_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import accdp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic op_valid_i = 1'b0;
  accdp_op_t op_i = ACCDP_NOP;
  logic [3:0] shift_i = 4'h0;
  logic [7:0] direct_addr_i = 8'h00;
  logic indirect_i = 1'b0;
  logic [15:0] imm_i = 16'h0000;
  logic [15:0] status_wdata_i = 16'h0000;
  logic [2:0] port_sel_i = 3'h7;
  logic [15:0] dm [256];
  logic [15:0] q [$];
  logic [15:0] r = 16'h003f;
  logic bt;
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  wire logic [15:0] dmem_rdata_i, pmem_rdata_i, port_rdata_i, dmem_wdata_o;
  wire logic [15:0] pmem_addr_o, pmem_wdata_o, port_wdata_o;
  wire logic [7:0] dmem_addr_o;
  wire logic [2:0] port_addr_o;
  wire logic [31:0] acc_o;
  wire logic busy_o, dmem_we_o, pmem_re_o, pmem_we_o, port_re_o, port_we_o, branch_taken_o;
  wire logic sat_o, flag_o, aux_ptr_o;
  assign dmem_rdata_i = dm[dmem_addr_o];
  accdp_core accdp_core_inst (.ref_clk_i, .reset_n_i, .op_valid_i, .op_i, .dmem_rdata_i,
    .shift_i, .direct_addr_i, .indirect_i, .post_inc_i(indirect_i), .new_ptr_valid_i(1'b0),
    .new_ptr_i(1'b0), .imm_i, .status_wdata_i, .port_sel_i, .port_rdata_i,
    .pmem_rdata_i, .busy_o, .dmem_addr_o, .dmem_we_o, .dmem_wdata_o, .pmem_addr_o,
    .pmem_re_o, .pmem_we_o, .pmem_wdata_o, .port_addr_o, .port_re_o, .port_we_o,
    .port_wdata_o, .branch_taken_o, .acc_o, .saturate_enable_bit_o(sat_o),
    .range_exceed_flag_o(flag_o), .aux_ptr_o);
  accdp_far_model accdp_far_model_inst (.clk_i(ref_clk_i), .pm_addr_i(pmem_addr_o),
    .pm_re_i(pmem_re_o), .pm_we_i(pmem_we_o), .pm_wdata_i(pmem_wdata_o), .pt_sel_i(port_sel_i),
    .pt_addr_i(port_addr_o), .pt_we_i(port_we_o), .pt_wdata_i(port_wdata_o),
    .pm_rdata_o(pmem_rdata_i), .pt_rdata_o(port_rdata_i));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  function automatic logic [15:0] lf(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lf
  task automatic ck(string nm, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask : ck
  task automatic op(accdp_op_t o, logic [7:0] a = 8'h00, logic [3:0] sh = 4'h0);
    op_i = o;
    direct_addr_i = a;
    imm_i = 16'(a);
    shift_i = sh;
    op_valid_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    op_valid_i = 1'b0;
    bt = branch_taken_o;
    for (int i = 0; i < 8 && busy_o !== 1'b0; i++) @(posedge ref_clk_i) #1;
    @(posedge ref_clk_i);
    #1;
  endtask : op
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // each write strobe takes the oldest expected word
  always @(negedge ref_clk_i) begin
    if (dmem_we_o === 1'b1 || pmem_we_o === 1'b1 || port_we_o === 1'b1) begin
      if (q.size() == 0) ck("write", 0, 1);
      else ck("wdata", 32'(q.pop_front()), 32'(dmem_we_o === 1'b1 ? dmem_wdata_o :
        pmem_we_o === 1'b1 ? pmem_wdata_o : port_wdata_o));
    end
  end
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end
  initial begin
    for (int i = 0; i < 256; i++) begin
      r = lf(r);
      dm[i] = r;
    end
    dm[1] = 16'h7fff;
    dm[2] = 16'h8000;
    repeat (12) @(posedge ref_clk_i);
    #1;
    reset_n_i = 1'b1;
    ck("acc rst", ACC_RESET, acc_o);
    op(ACCDP_SAT_ON);
    op(ACCDP_LOAD_SHIFTED, 1, 15);
    op(ACCDP_ADD, 1, 15);
    ck("sum", 32'h7fff0000, acc_o);
    op(ACCDP_ADD, 1, 15);
    ck("pos sat", ACC_MAX_POS, acc_o);
    ck("flag", 1, flag_o);
    op(ACCDP_BR_RANGE);
    ck("bv", 1, bt);
    op(ACCDP_BR_RANGE);
    ck("bv idle", 0, bt);
    op(ACCDP_LOAD_SHIFTED, 2, 15);
    op(ACCDP_ADD, 2, 15);
    op(ACCDP_SUB, 1);
    ck("neg sat", ACC_MAX_NEG, acc_o);
    op(ACCDP_SAT_OFF);
    op(ACCDP_BR_RANGE);
    op(ACCDP_LOAD_SHIFTED, 1, 15);
    repeat (2) op(ACCDP_ADD, 1, 15);
    ck("wrap", 32'hbffe8000, acc_o);
    op(ACCDP_CLEAR_ACC);
    ck("sticky", 1, flag_o);
    op(ACCDP_BR_ZERO);
    ck("bz", 1, bt);
    status_wdata_i = 16'h0400;
    op(ACCDP_STATUS_RELOAD);
    ck("reload", 2'b10, {sat_o, flag_o});
    op(ACCDP_LOAD_SHIFTED, 2);
    op(ACCDP_MAGNITUDE);
    op(ACCDP_PUSH);
    op(ACCDP_CLEAR_ACC);
    op(ACCDP_POP);
    ck("abs pop", 32'h00008000, acc_o);
    q.push_back(16'h0000);
    op(ACCDP_STORE_HIGH, 9);
    q.push_back(16'h8000);
    op(ACCDP_STORE_LOW, 9);
    for (int i = 16; i < 20; i++) begin
      op(ACCDP_LOAD_SHIFTED, 8'(i));
      op(ACCDP_XOR, 8'(i + 8));
      ck("xor", {{16{dm[i][15]}}, dm[i] ^ dm[i + 8]}, acc_o);
      op(ACCDP_OR, 8'(i + 16));
      op(ACCDP_AND, 8'(i + 24));
      ck("and", {16'h0, ((dm[i] ^ dm[i + 8]) | dm[i + 16]) & dm[i + 24]}, acc_o);
    end
    op(ACCDP_ZERO_LOAD_HIGH, 3);
    ck("zlh", {dm[3], 16'h0000}, acc_o);
    op(ACCDP_LOAD_SHIFTED, 30);
    q.push_back(dm[31]);
    op(ACCDP_D2P_COPY, 31);
    q.push_back(dm[31]);
    op(ACCDP_P2D_COPY, 40);
    q.push_back(dm[50]);
    op(ACCDP_PORT_OUT, 50);
    q.push_back(dm[50]);
    op(ACCDP_PORT_IN, 51);
    op(ACCDP_AUX_PTR_SEL, 0);
    op(ACCDP_AUX_LOAD_IMM, 3);
    n = 1;
    op(ACCDP_LOOP_BR);
    while (bt === 1'b1 && n < 9) begin
      n++;
      op(ACCDP_LOOP_BR);
    end
    ck("passes", 4, n);
    indirect_i = 1'b1;
    repeat (2) op(ACCDP_ZERO_LOAD_LOW);
    indirect_i = 1'b0;
    ck("post inc", {16'h0000, dm[1]}, acc_o);
    ck("queue", 0, q.size());
    end_sim;
  end
endmodule : tb
`default_nettype wire
